// ===== seq_clock_partner.sv
// Far side of the clock pin: external clock source and the pulled-up open-drain wire.
// Assumes the bench raises ext_run only while the device is set to the external source.
`timescale 1ns/100ps
module seq_clock_partner (
    input  wire logic       clk,          // System clock.
    input  wire logic       ext_run,      // Drive a clock onto the pin.
    input  wire logic [3:0] half_cycles,  // System clocks per half period.
    input  wire logic       clk_pin_oe,   // Device sinks the pin.
    input  wire logic       clk_pin_out,  // Device drive value.
    output logic            pin_level     // Resolved pin level.
);
    logic [3:0] half_cnt = 4'h0;
    logic       ext_clk  = 1'b0;

    // The source stands low between frames, but the pin then idles high, so a frame stopped in a low half leaves one rising edge for the prescalers.
    always @(negedge clk) begin
        if (!ext_run) begin
            half_cnt <= 4'h0;
            ext_clk  <= 1'b0;
        end else if (half_cnt == half_cycles - 4'h1) begin
            half_cnt <= 4'h0;
            ext_clk  <= ~ext_clk;
        end else begin
            half_cnt <= half_cnt + 4'h1;
        end
    end

    // With nobody sinking it the pull-up wins.
    assign pin_level = (clk_pin_oe && !clk_pin_out) ? 1'b0 : (ext_run ? ext_clk : 1'b1);
endmodule : seq_clock_partner

// ===== seq_clock_prescaler_timers.sv
// Clock generation, prescalers, two delay timers and the macrocell slice.
// Assumes configuration ports are static and pins are asynchronous to clk.
`timescale 1ns/100ps
`include "seq_consts.svh"
module seq_clock_prescaler_timers #(
    parameter int MC_COUNT    = `MC_COUNT,
    parameter int TIMER_COUNT = `TIMER_COUNT
) (
    input  wire logic                  clk,                 // 25 MHz clock.
    input  wire logic                  reset,               // Power-on reset.
    input  wire logic                  global_reset_n_pin,  // Reset pin, low.
    input  wire logic                  clk_pin_in,          // Clock pin level.
    output logic                       clk_pin_out,         // Clock pin drive.
    output logic                       clk_pin_oe,          // Pulls pin low.
    input  wire logic [`MONITOR_COUNT-1:0] monitor_in,      // Comparator levels.
    input  wire logic [`DIGITAL_COUNT-1:0] digital_in,      // Digital inputs.
    input  wire seq_pkg::clk_src_type  clk_source_cfg,      // Clock source.
    input  wire seq_pkg::div_sel_type  array_div_cfg,       // Array divider.
    input  wire seq_pkg::div_sel_type  timer_div_cfg,       // Timer divider.
    input  wire seq_pkg::div_sel_type  timer_end_cfg  [TIMER_COUNT], // Ends.
    input  wire seq_pkg::div_sel_type  timer_ctrl_cfg [TIMER_COUNT], // Ctrl.
    input  wire seq_pkg::term_mask_type term_true_cfg [`TERM_COUNT], // True.
    input  wire seq_pkg::term_mask_type term_comp_cfg [`TERM_COUNT], // Comp.
    input  wire logic [`TERM_COUNT-1:0] term_used_cfg,      // Term in use.
    input  wire logic [MC_COUNT-1:0]   mc_invert_cfg,       // Polarity.
    input  wire logic [MC_COUNT-1:0]   mc_bypass_cfg,       // Bypass.
    input  wire logic [MC_COUNT-1:0]   mc_toggle_cfg,       // T-type.
    input  wire logic [MC_COUNT-1:0]   mc_borrow_cfg,       // Borrow next.
    input  wire logic [MC_COUNT-1:0]   mc_pt_reset_cfg,     // Term resets.
    input  wire logic [MC_COUNT-1:0]   mc_pt_preset_cfg,    // Term presets.
    input  wire logic [MC_COUNT-1:0]   mc_pin_reset_cfg,    // Pin resets.
    output logic [MC_COUNT-1:0]        mc_out,              // Macrocells.
    output logic [TIMER_COUNT-1:0]     timer_done           // Timer outputs.
);
    import seq_pkg::*;

    // The power-of-two divider tap is decoded for both prescalers.
    function automatic logic div_hit(input logic [`PRESC_W-1:0] cnt,
                                     input logic [3:0]          shift);
        logic [`PRESC_W-1:0] mask;
        mask = `PRESC_W'(({1'b0, {`PRESC_W{1'b0}}} | 10'h001) << shift) -
               `PRESC_W'(1);
        return (cnt & mask) == mask;
    endfunction : div_hit

    // Input synchronisers: reset pin, clock pin, monitors, digital inputs.
    logic [`SYNC_W-1:0] sync_raw;
    logic [`SYNC_W-1:0] sync1_reg;
    logic [`SYNC_W-1:0] sync2_reg;
    logic               global_clear;
    logic               ext_level;
    logic [`MONITOR_COUNT-1:0] monitor_level;
    logic [`DIGITAL_COUNT-1:0] digital_level;

    assign sync_raw      = {~global_reset_n_pin, clk_pin_in, monitor_in, digital_in};
    assign global_clear  = sync2_reg[`SYNC_W-1];
    assign ext_level     = sync2_reg[`SYNC_W-2];
    assign monitor_level = sync2_reg[`DIGITAL_COUNT +: `MONITOR_COUNT];
    assign digital_level = sync2_reg[`DIGITAL_COUNT-1:0];

    always_ff @(posedge clk) begin
        // Reset to the pins' idle levels, so the pulled-up clock pin shows no
        // false rising edge to the external edge detector after reset.
        if (reset) begin
            sync1_reg <= `SYNC_IDLE;
            sync2_reg <= `SYNC_IDLE;
        end else begin
            sync1_reg <= sync_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // Oscillator, external edge detect and source selection.
    logic [`OSC_CNT_W-1:0] osc_cnt_reg;
    logic [`OSC_CNT_W-1:0] osc_cnt_next;
    logic                  osc_level_reg;
    logic                  osc_level_next;
    logic                  osc_tick;
    logic                  ext_prev_reg;
    logic                  ext_tick;
    logic                  src_tick;
    logic                  internal_mode;

    assign osc_tick      = (osc_cnt_reg == `OSC_CNT_W'(`OSC_DIV - 1));
    assign ext_tick      = ext_level & ~ext_prev_reg;
    assign internal_mode = (clk_source_cfg == SRC_INTERNAL);
    // One tick stream feeds both prescalers from whichever source is chosen.
    assign src_tick      = internal_mode ? osc_tick : ext_tick;

    always_comb begin
        osc_cnt_next   = osc_tick ? '0 : osc_cnt_reg + 1'b1;
        osc_level_next = (osc_cnt_next < `OSC_CNT_W'(`OSC_HALF));
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            osc_cnt_reg   <= '0;
            osc_level_reg <= 1'b0;
            ext_prev_reg  <= 1'b1;
        end else begin
            osc_cnt_reg   <= osc_cnt_next;
            osc_level_reg <= osc_level_next;
            ext_prev_reg  <= ext_level;
        end
    end

    // Shared prescaler counter; each divider taps its own power of two.
    logic [`PRESC_W-1:0] presc_cnt_reg;
    logic [`PRESC_W-1:0] presc_cnt_next;
    logic                array_tick;
    logic                timer_tick;
    logic [3:0]          timer_shift;
    logic                array_level;

    assign timer_shift = {1'b0, timer_div_cfg} + 4'(`TIMER_MIN_SHIFT);
    assign array_tick  = src_tick & div_hit(presc_cnt_reg, {1'b0, array_div_cfg});
    assign timer_tick  = src_tick & div_hit(presc_cnt_reg, timer_shift);

    // The array clock level for the pin follows the matching counter bit, or the
    // oscillator level when undivided, so the pin shows the same frequency as the array clock tick rate.
    always_comb begin
        presc_cnt_next = src_tick ? presc_cnt_reg + 1'b1 : presc_cnt_reg;
        if (array_div_cfg == 3'h0) begin
            array_level = osc_level_reg;
        end else begin
            array_level = presc_cnt_reg[array_div_cfg - 3'h1];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            presc_cnt_reg <= '0;
        end else begin
            presc_cnt_reg <= presc_cnt_next;
        end
    end

    // Open-drain clock output: only ever pulls low, never drives high.
    logic pin_oe_reg;
    logic pin_oe_next;
    logic pin_out_reg;

    assign clk_pin_oe  = pin_oe_reg;
    assign clk_pin_out = pin_out_reg;

    always_comb begin
        pin_oe_next = internal_mode & ~array_level;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_oe_reg  <= 1'b0;
            pin_out_reg <= 1'b0;
        end else begin
            pin_oe_reg  <= pin_oe_next;
            pin_out_reg <= 1'b0;
        end
    end

    // AND array. Macrocell and timer feedback use registered copies, which
    // breaks the combinational loop a bypassed macrocell would otherwise make.
    logic [`ARRAY_INPUTS-1:0] array_in;
    logic [`TERM_COUNT-1:0]   term;
    logic [MC_COUNT-1:0]      mc_out_reg;
    logic [MC_COUNT-1:0]      mc_out_next;
    logic [TIMER_COUNT-1:0]   timer_done_w;

    assign array_in = {timer_done_w, mc_out_reg, digital_level, monitor_level};

    genvar t;
    generate
        for (t = 0; t < `TERM_COUNT; t++) begin : g_term
            assign term[t] = term_used_cfg[t] &
                             (&(~term_true_cfg[t] | array_in)) &
                             (&(~term_comp_cfg[t] | ~array_in));
        end
    endgenerate

    // Macrocells with neighbour sharing and reset/preset sources.
    logic [MC_COUNT-1:0] own_sum;
    logic [MC_COUNT-1:0] cell_out;

    genvar j;
    generate
        for (j = 0; j < MC_COUNT; j++) begin : g_mc
            seq_macrocell u_cell (
                .clk        (clk),
                .reset      (reset),
                .array_tick (array_tick),
                .terms      (term[j*`TERMS_PER_MC +: `TERMS_PER_MC]),
                .borrow_in  (mc_borrow_cfg[j] & own_sum[(j + 1) % MC_COUNT]),
                .invert     (mc_invert_cfg[j]),
                .bypass     (mc_bypass_cfg[j]),
                .toggle     (mc_toggle_cfg[j]),
                .ff_reset   ((mc_pt_reset_cfg[j] & term[`CTRL_TERM]) |
                             (mc_pin_reset_cfg[j] & global_clear)),
                .ff_preset  (mc_pt_preset_cfg[j] & term[`CTRL_TERM]),
                .own_sum    (own_sum[j]),
                .cell_out   (cell_out[j])
            );
        end
    endgenerate

    assign mc_out = mc_out_reg;

    always_comb begin
        mc_out_next = cell_out;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mc_out_reg <= '0;
        end else begin
            mc_out_reg <= mc_out_next;
        end
    end

    // Delay timers on the shared timer tick.
    genvar k;
    generate
        for (k = 0; k < TIMER_COUNT; k++) begin : g_timer
            seq_delay_timer u_timer (
                .clk     (clk),
                .reset   (reset),
                .clear   (global_clear),
                .tick    (timer_tick),
                .control (mc_out_reg[timer_ctrl_cfg[k]]),
                .end_sel (timer_end_cfg[k]),
                .done    (timer_done_w[k])
            );
        end
    endgenerate

    assign timer_done = timer_done_w;
endmodule : seq_clock_prescaler_timers

// ===== seq_clock_prescaler_timers_bench.sv
// Bench for the clock, prescaler, timer and macrocell slice.
// Assumes seq_consts.svh is on the include path; inputs change at the falling edge.
`timescale 1ns/100ps
`include "seq_consts.svh"
module seq_clock_prescaler_timers_bench;
    import seq_pkg::*;
    logic                      clk = 1'b0;
    logic                      reset = 1'b1;
    logic                      global_reset_n_pin = 1'b1;
    logic                      clk_pin_in, clk_pin_out, clk_pin_oe;
    logic [`MONITOR_COUNT-1:0] monitor_in = '0;
    logic [`DIGITAL_COUNT-1:0] digital_in = '0;
    clk_src_type               clk_source_cfg;
    div_sel_type               array_div_cfg, timer_div_cfg;
    div_sel_type               timer_end_cfg [2], timer_ctrl_cfg [2];
    term_mask_type             term_true_cfg [`TERM_COUNT], term_comp_cfg [`TERM_COUNT];
    logic [`TERM_COUNT-1:0]    term_used_cfg;
    logic [7:0]                mc_invert_cfg, mc_bypass_cfg, mc_toggle_cfg, mc_borrow_cfg;
    logic [7:0]                mc_pt_reset_cfg, mc_pt_preset_cfg, mc_pin_reset_cfg, mc_out;
    logic [1:0]                timer_done;
    logic                      ext_run = 1'b0;
    logic                      oe_any;
    int                        num_errors = 0, cmp_count = 0, n, n2;

    initial forever #20 clk = ~clk;

    seq_clock_prescaler_timers i_dut (.clk, .reset, .global_reset_n_pin, .clk_pin_in,
        .clk_pin_out, .clk_pin_oe, .monitor_in, .digital_in, .clk_source_cfg, .array_div_cfg,
        .timer_div_cfg, .timer_end_cfg, .timer_ctrl_cfg, .term_true_cfg, .term_comp_cfg,
        .term_used_cfg, .mc_invert_cfg, .mc_bypass_cfg, .mc_toggle_cfg, .mc_borrow_cfg,
        .mc_pt_reset_cfg, .mc_pt_preset_cfg, .mc_pin_reset_cfg, .mc_out, .timer_done);
    seq_clock_partner i_far (.clk, .ext_run, .half_cycles(4'h4), .clk_pin_oe, .clk_pin_out,
        .pin_level(clk_pin_in));

    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        cmp_count++;
        if (seen !== expected) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    // Configuration is static, so it is only changed while reset is held.
    task automatic enter_reset();
        @(negedge clk);
        reset = 1'b1;
        clk_source_cfg = SRC_INTERNAL;
        {array_div_cfg, timer_div_cfg, term_used_cfg} = '0;
        {mc_invert_cfg, mc_bypass_cfg, mc_toggle_cfg, mc_borrow_cfg} = '0;
        {mc_pt_reset_cfg, mc_pt_preset_cfg, mc_pin_reset_cfg} = '0;
        timer_end_cfg = '{2{3'h0}};
        timer_ctrl_cfg = '{2{3'h0}};
        term_true_cfg = '{`TERM_COUNT{20'h0}};
        term_comp_cfg = '{`TERM_COUNT{20'h0}};
    endtask : enter_reset

    task automatic leave_reset();
        repeat (6) @(negedge clk);
        reset = 1'b0;
    endtask : leave_reset

    task automatic wait_low_span(output int span);
        int guard;
        guard = 0;
        while (clk_pin_in !== 1'b1 && guard < 2000) begin
            @(negedge clk);
            guard++;
        end
        while (clk_pin_in !== 1'b0 && guard < 2000) begin
            @(negedge clk);
            guard++;
        end
        for (span = 0; clk_pin_in === 1'b0 && span < 2000; span++) @(negedge clk);
    endtask : wait_low_span

    task automatic wait_done(input int idx, output int span);
        for (span = 0; timer_done[idx] !== 1'b1 && span < 4000; span++) @(negedge clk);
    endtask : wait_done

    task automatic count_toggles(input int span, output int tog);
        logic prev;
        prev = mc_out[2];
        tog = 0;
        repeat (span) begin
            @(negedge clk);
            tog += int'(mc_out[2] !== prev);
            prev = mc_out[2];
            oe_any |= clk_pin_oe;
        end
    endtask : count_toggles

    task automatic tally_and_finish();
        $display("TB: %0d mismatches in %0d comparisons", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        for (int sel = 0; sel < 3; sel++) begin
            enter_reset();
            array_div_cfg = 3'(sel);
            leave_reset();
            wait_low_span(n);
            wait_low_span(n);
            check(16'(n), 16'h0032 << sel);
        end
        // Cell 0 follows monitor 0 for timer one; cell 3 follows digital 0 for timer two.
        enter_reset();
        term_used_cfg[0] = 1'b1;
        term_true_cfg[0][0] = 1'b1;
        term_used_cfg[15] = 1'b1;
        term_true_cfg[15][6] = 1'b1;
        mc_bypass_cfg = 8'h09;
        timer_ctrl_cfg[1] = 3'h3;
        timer_end_cfg[1] = 3'h1;
        leave_reset();
        monitor_in[0] = 1'b1;
        digital_in[0] = 1'b1;
        wait_done(0, n);
        check(16'(n >= 400 && n <= 810), 16'h0001);
        wait_done(1, n2);
        check(16'(n + n2 >= 1200 && n + n2 <= 1610), 16'h0001);
        repeat (50) @(negedge clk);
        check(16'(timer_done), 16'h0003);
        monitor_in[0] = 1'b0;
        repeat (8) @(negedge clk);
        check(16'(timer_done), 16'h0002);
        global_reset_n_pin = 1'b0;
        repeat (8) @(negedge clk);
        check(16'(timer_done), 16'h0000);
        global_reset_n_pin = 1'b1;
        // External clock of eight system clocks; cell 2 toggles on every array tick.
        enter_reset();
        clk_source_cfg = SRC_EXTERNAL;
        array_div_cfg = 3'h1;
        timer_div_cfg = 3'h1;
        term_used_cfg[0] = 1'b1;
        term_used_cfg[10] = 1'b1;
        mc_bypass_cfg = 8'h01;
        mc_toggle_cfg = 8'h04;
        leave_reset();
        ext_run = 1'b1;
        oe_any = 1'b0;
        wait_done(0, n);
        check(16'(n >= 64 && n <= 140), 16'h0001);
        count_toggles(320, n);
        check(16'(n >= 19 && n <= 21), 16'h0001);
        check(16'(oe_any), 16'h0000);
        ext_run = 1'b0;
        repeat (8) @(negedge clk);
        count_toggles(100, n);
        check(16'(n), 16'h0000);
        // Cell 0 borrows cell 1, cell 2 is cleared by the shared term, cell 5 takes a complement.
        enter_reset();
        term_used_cfg[9] = 1'b1;
        term_true_cfg[9][7] = 1'b1;
        term_used_cfg[25] = 1'b1;
        term_comp_cfg[25][2] = 1'b1;
        term_used_cfg[40] = 1'b1;
        term_true_cfg[40][1] = 1'b1;
        mc_invert_cfg[4] = 1'b1;
        term_used_cfg[10] = 1'b1;
        mc_bypass_cfg = 8'h31;
        mc_borrow_cfg[0] = 1'b1;
        mc_pt_reset_cfg[2] = 1'b1;
        mc_pin_reset_cfg[1] = 1'b1;
        mc_pt_preset_cfg[6] = 1'b1;
        leave_reset();
        digital_in = 4'h2;
        repeat (250) @(negedge clk);
        check(16'(mc_out), 16'h0037);
        monitor_in[1] = 1'b1;
        repeat (8) @(negedge clk);
        check(16'(mc_out), 16'h0073);
        global_reset_n_pin = 1'b0;
        repeat (8) @(negedge clk);
        check(16'(mc_out), 16'h0071);
        global_reset_n_pin = 1'b1;
        tally_and_finish();
    end

    // The whole sequence needs well under ten thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule : seq_clock_prescaler_timers_bench

// ===== seq_consts.svh
// Constants for the sequencer clock, prescaler, timer and macrocell slice.
// Assumes a 25 MHz system clock; all slower clocks are made as one-cycle ticks.
// Overview of operation
// - Fixed 250 kHz oscillator feeds both prescalers.
// - Array clock divides source by one to 128.
// - Internal mode: clock pin is open-drain array clock.
// - External mode: pin is input feeding both prescalers.
// - Timer clock divides source by four to 512.
// - Both timers share one timer clock.
// - Each timer has own doubling end count.
// - Internal timeouts span 32 us to 524 ms.
// - Timer control selectable from any macrocell output.
// - Timer cleared by reset pin, power-on, low control.
// - External mode timeouts follow external clock rate.
// - Eight macrocells, each D or T flip-flop.
// - Bypass sends sum straight to macrocell output.
// - Polarity XOR applied to each sum.
// - Macrocell flip-flops use common array clock.
// - Reset from terms, pin, power-on; preset from terms only.
// - Each macrocell ORs five product terms.
// - AND array 20 inputs, 41 terms, sharing.
// - Comparator levels enter array as high/low.
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

`define CLK_FREQ_KHZ      25000
`define OSC_FREQ_KHZ      250
`define OSC_DIV           (`CLK_FREQ_KHZ / `OSC_FREQ_KHZ)
`define OSC_HALF          (`OSC_DIV / 2)
`define OSC_CNT_W         7
`define PRESC_W           9
`define TIMER_MIN_SHIFT   2
`define TIMER_CNT_W       9
`define TIMER_MIN_END     2
`define TIMER_MIN_US      32
`define TIMER_MAX_US      524288
`define MC_COUNT          8
`define TERMS_PER_MC      5
`define ARRAY_INPUTS      20
`define TERM_COUNT        41
`define CTRL_TERM         40
`define TIMER_COUNT       2
`define MONITOR_COUNT     6
`define DIGITAL_COUNT     4
`define SYNC_W            12
`define SYNC_IDLE         12'h400

`endif

// ===== seq_delay_timer.sv
// One delay timer counting shared timer-clock ticks.
// Assumes tick is a one-cycle pulse on clk and control is already on clk.
`timescale 1ns/100ps
`include "seq_consts.svh"
module seq_delay_timer (
    input  wire logic                 clk,       // System clock.
    input  wire logic                 reset,     // Power-on reset, high.
    input  wire logic                 clear,     // Global reset pin, high.
    input  wire logic                 tick,      // Timer clock tick.
    input  wire logic                 control,   // Run while high.
    input  wire seq_pkg::div_sel_type end_sel,   // End count is 2 shl sel.
    output logic                      done       // Timeout reached.
);
    import seq_pkg::*;

    timer_cnt_type count_reg;
    timer_cnt_type count_next;
    timer_cnt_type end_count;
    logic          done_reg;
    logic          done_next;

    assign end_count = timer_cnt_type'(`TIMER_MIN_END) << end_sel;
    assign done      = done_reg;

    always_comb begin
        count_next = count_reg;
        done_next  = done_reg;
        if (clear || !control) begin
            count_next = '0;
            done_next  = 1'b0;
        end else if (tick && !done_reg) begin
            count_next = count_reg + 1'b1;
            if (count_next == end_count) begin
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count_reg <= '0;
            done_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            done_reg  <= done_next;
        end
    end
endmodule : seq_delay_timer

// ===== seq_macrocell.sv
// One logic-array macrocell: five-term OR, polarity, D/T flip-flop, bypass.
// Assumes array_tick is the one-cycle logic-array clock tick on clk.
`timescale 1ns/100ps
`include "seq_consts.svh"
module seq_macrocell (
    input  wire logic                     clk,         // System clock.
    input  wire logic                     reset,       // Power-on reset, high.
    input  wire logic                     array_tick,  // Array clock tick.
    input  wire logic [`TERMS_PER_MC-1:0] terms,       // Own product terms.
    input  wire logic                     borrow_in,   // Neighbour sum lent.
    input  wire logic                     invert,      // Polarity select.
    input  wire logic                     bypass,      // Combinational out.
    input  wire logic                     toggle,      // T-type when high.
    input  wire logic                     ff_reset,    // Clear flip-flop.
    input  wire logic                     ff_preset,   // Set flip-flop.
    output logic                          own_sum,     // OR of own terms.
    output logic                          cell_out     // Macrocell output.
);
    import seq_pkg::*;

    logic sum;
    logic q_reg;
    logic q_next;

    assign own_sum  = |terms;
    assign sum      = (own_sum | borrow_in) ^ invert;
    assign cell_out = bypass ? sum : q_reg;

    // Reset and preset act on any system clock, not only on an array tick,
    // so they behave as asynchronous controls seen from the array clock.
    always_comb begin
        q_next = q_reg;
        if (ff_reset) begin
            q_next = 1'b0;
        end else if (ff_preset) begin
            q_next = 1'b1;
        end else if (array_tick) begin
            q_next = toggle ? (q_reg ^ sum) : sum;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end
endmodule : seq_macrocell

// ===== seq_pkg.sv
// Types shared by the sequencer clock, timer and macrocell modules.
// Assumes seq_consts.svh is on the include path.
`include "seq_consts.svh"
package seq_pkg;
    typedef enum logic {
        SRC_INTERNAL = 1'b0,
        SRC_EXTERNAL = 1'b1
    } clk_src_type;
    typedef logic [2:0]                   div_sel_type;
    typedef logic [`ARRAY_INPUTS-1:0]     term_mask_type;
    typedef logic [`TIMER_CNT_W-1:0]      timer_cnt_type;
endpackage : seq_pkg

// ===== seq_timing_props.sv
// Checker for the clock pin, timers and macrocell resets, bound to the top module.
// Assumes configuration only changes while reset is high.
`timescale 1ns/100ps
module seq_timing_props #(
    parameter int MC_COUNT    = 8,
    parameter int TIMER_COUNT = 2
) (
    input wire logic                 clk,                 // System clock.
    input wire logic                 reset,               // Power-on reset.
    input wire logic                 global_reset_n_pin,  // Reset pin, low.
    input wire logic                 clk_pin_out,         // Clock pin drive.
    input wire logic                 clk_pin_oe,          // Pulls pin low.
    input wire seq_pkg::clk_src_type clk_source_cfg,      // Clock source.
    input wire seq_pkg::div_sel_type array_div_cfg,       // Array divider.
    input wire seq_pkg::div_sel_type timer_div_cfg,       // Timer divider.
    input wire seq_pkg::div_sel_type timer_end_cfg  [TIMER_COUNT], // Ends.
    input wire seq_pkg::div_sel_type timer_ctrl_cfg [TIMER_COUNT], // Ctrl.
    input wire logic [MC_COUNT-1:0]  mc_bypass_cfg,       // Bypass.
    input wire logic [MC_COUNT-1:0]  mc_pin_reset_cfg,    // Pin resets.
    input wire logic [MC_COUNT-1:0]  mc_out,              // Macrocells.
    input wire logic [TIMER_COUNT-1:0] timer_done         // Timer outputs.
);
    import seq_pkg::*;
    logic [15:0] oe_run;
    logic        oe_seen;
    logic [19:0] ctl_run;
    logic        ctl0;
    int          period;
    int          ends;

    assign ctl0   = mc_out[timer_ctrl_cfg[0]];
    assign period = 400 << timer_div_cfg;
    assign ends   = 2 << timer_end_cfg[0];

    // The first low-drive span after reset may be cut short, so it is not judged.
    always_ff @(posedge clk) begin
        if (reset) begin
            oe_run  <= 16'h0;
            oe_seen <= 1'b0;
            ctl_run <= 20'h0;
        end else begin
            oe_run  <= clk_pin_oe ? oe_run + 16'h1 : 16'h0;
            oe_seen <= oe_seen | (!clk_pin_oe && oe_run != 16'h0);
            ctl_run <= ctl0 ? ctl_run + 20'h1 : 20'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_pin_out_low: assert property (!clk_pin_out)
        else $error("clock pin drive value is not low");
    chk_oe_ext_off: assert property ((clk_source_cfg == SRC_EXTERNAL) &&
        ($past(clk_source_cfg) == SRC_EXTERNAL) |-> !clk_pin_oe)
        else $error("clock pin driven in external mode");
    chk_oe_half_span: assert property ($fell(clk_pin_oe) && oe_seen &&
        (clk_source_cfg == SRC_INTERNAL) |-> oe_run == (16'h0032 << array_div_cfg))
        else $error("clock pin low span differs from half the array period");
    chk_done_needs_ctrl: assert property ($rose(timer_done[0]) |-> $past(ctl0))
        else $error("timer finished without its control high");
    chk_ctrl_low_clears: assert property (!ctl0 |=> !timer_done[0])
        else $error("timer not cleared by low control");
    chk_pin_clears_timers: assert property (!global_reset_n_pin [*3] |=> timer_done == '0)
        else $error("timer not cleared by reset pin");
    chk_pin_clears_cells: assert property (!global_reset_n_pin [*5] |=>
        (mc_out & mc_pin_reset_cfg & ~mc_bypass_cfg) == '0)
        else $error("macrocell not cleared by reset pin");
    chk_done_holds: assert property (global_reset_n_pin [*4] ##0 (timer_done[0] && ctl0)
        |=> timer_done[0])
        else $error("timer output dropped while enabled");
    chk_timeout_span: assert property ($rose(timer_done[0]) &&
        (clk_source_cfg == SRC_INTERNAL) |-> ctl_run >= (ends - 1) * period &&
        ctl_run <= ends * period + 4)
        else $error("timer timeout outside the configured span");

    cov_done0: cover property ($rose(timer_done[0]));
    cov_done1: cover property ($rose(timer_done[1]));
    cov_oe_fall: cover property ($fell(clk_pin_oe) && oe_seen);
    cov_ext_toggle: cover property ((clk_source_cfg == SRC_EXTERNAL) && $rose(mc_out[2]));
endmodule : seq_timing_props

bind seq_clock_prescaler_timers seq_timing_props #(
    .MC_COUNT(MC_COUNT),
    .TIMER_COUNT(TIMER_COUNT)
) i_props (
    .clk, .reset, .global_reset_n_pin, .clk_pin_out, .clk_pin_oe, .clk_source_cfg,
    .array_div_cfg, .timer_div_cfg, .timer_end_cfg, .timer_ctrl_cfg, .mc_bypass_cfg,
    .mc_pin_reset_cfg, .mc_out, .timer_done
);
